// ### core/sprite_plane_control.sv
/*
 * sprite plane control: register bank with vblank double buffering, active
 * mode decode towards the pixel path, fetch setup and colour-key compare.
 * assumes vblank is a synchronous level from the assigned pipe, and that the
 * register port strobes are single-cycle and never overlap.
 */
// Added by the designer: the plain strobed port.
`default_nettype none
module sprite_plane_control
   import sprite_plane_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire sprite_plane_pkg::reg_req_t req,
   output logic [31:0] rdata,
   input wire logic vblank,
   input wire sprite_plane_pkg::pix_in_t pix_in,
   output sprite_plane_pkg::pixel_mode_t mode,
   output sprite_plane_pkg::fetch_cfg_t fetch,
   output sprite_plane_pkg::key_cfg_t keys,
   output sprite_plane_pkg::key_out_t key_out
);
   // pending (software-visible) copies
   logic [31:0] ctl_q, lin_q, stride_q, pos_q, size_q, kval_q, kmsk_q, surf_q, kmax_q;
   // active copies
   logic [31:0] a_ctl_q, a_lin_q, a_stride_q, a_pos_q, a_size_q;
   logic [31:0] a_kval_q, a_kmsk_q, a_surf_q, a_kmax_q;
   logic armed_q, vblank_q, vb_rise;
   logic [31:0] wd;
   plane_state_t state_q;

   assign vb_rise = vblank & ~vblank_q;
   assign wd = req.wdata;

   always_ff @(posedge clk) begin
      if (srst) begin
         vblank_q <= 1'b0;
      end else begin
         vblank_q <= vblank;
      end
   end

   // write path; reserved bits are dropped on the way in
   always_ff @(posedge clk) begin
      if (srst) begin
         ctl_q <= RST_WORD;
         lin_q <= RST_WORD;
         stride_q <= RST_WORD;
         pos_q <= RST_WORD;
         size_q <= RST_WORD;
         kval_q <= RST_WORD;
         kmsk_q <= RST_WORD;
         surf_q <= RST_WORD;
         kmax_q <= RST_WORD;
      end else if (req.wr) begin
         case (req.addr)
            OFF_CONTROL: ctl_q <= wd & CONTROL_WMASK;
            OFF_LINEAR_OFFSET: lin_q <= wd;
            OFF_STRIDE: stride_q <= wd;
            OFF_POSITION: pos_q <= wd & XY_WMASK;
            OFF_SIZE: size_q <= wd & XY_WMASK;
            OFF_KEY_VALUE: kval_q <= wd & KEY_VALUE_WMASK;
            OFF_KEY_MASK: kmsk_q <= wd & KEY_MASK_WMASK;
            OFF_SURFACE_TRIGGER: surf_q <= wd & SURF_WMASK;
            OFF_KEY_MAXIMUM: kmax_q <= wd & KEY_VALUE_WMASK;
            default: ;
         endcase
      end
   end

   // arm: a surface write, or enable going zero to one, waits for vblank.
   // a trigger in the same cycle as the vblank edge stays armed for the next
   // one, so the flip never lands on a half-written register set.
   always_ff @(posedge clk) begin
      if (srst) begin
         armed_q <= 1'b0;
      end else if (req.wr && (req.addr == OFF_SURFACE_TRIGGER ||
                  (req.addr == OFF_CONTROL && req.wdata[CTL_ENABLE] && !ctl_q[CTL_ENABLE]))) begin
         armed_q <= 1'b1;
      end else if (vb_rise) begin
         armed_q <= 1'b0;
      end
   end

   // linear offset, position and size load on every vblank edge; the rest
   // wait for the trigger. disabling also lands on the vblank edge.
   always_ff @(posedge clk) begin
      if (srst) begin
         a_lin_q <= RST_WORD;
         a_pos_q <= RST_WORD;
         a_size_q <= RST_WORD;
      end else if (vb_rise) begin
         a_lin_q <= lin_q;
         a_pos_q <= pos_q;
         a_size_q <= size_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         a_ctl_q <= RST_WORD;
         a_stride_q <= RST_WORD;
         a_kval_q <= RST_WORD;
         a_kmsk_q <= RST_WORD;
         a_surf_q <= RST_WORD;
         a_kmax_q <= RST_WORD;
      end else if (vb_rise && armed_q) begin
         a_ctl_q <= ctl_q;
         a_stride_q <= stride_q;
         a_kval_q <= kval_q;
         a_kmsk_q <= kmsk_q;
         a_surf_q <= surf_q;
         a_kmax_q <= kmax_q;
      end else if (vb_rise && !ctl_q[CTL_ENABLE]) begin
         a_ctl_q[CTL_ENABLE] <= 1'b0;
      end
   end

   // plane state for status readback
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= PLANE_OFF;
      end else begin
         case (state_q)
            PLANE_OFF: if (armed_q && ctl_q[CTL_ENABLE]) state_q <= PLANE_ARMED;
            PLANE_ARMED: if (a_ctl_q[CTL_ENABLE]) state_q <= PLANE_ON;
               else if (!ctl_q[CTL_ENABLE]) state_q <= PLANE_OFF;
            PLANE_ON: if (!a_ctl_q[CTL_ENABLE]) state_q <= PLANE_OFF;
            default: state_q <= PLANE_OFF;
         endcase
      end
   end

   // read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= RST_WORD;
      end else if (req.rd) begin
         case (req.addr)
            OFF_CONTROL: rdata <= ctl_q;
            OFF_LINEAR_OFFSET: rdata <= lin_q;
            OFF_STRIDE: rdata <= stride_q;
            OFF_POSITION: rdata <= pos_q;
            OFF_SIZE: rdata <= size_q;
            OFF_KEY_VALUE: rdata <= kval_q;
            OFF_KEY_MASK: rdata <= kmsk_q;
            OFF_SURFACE_TRIGGER: rdata <= surf_q;
            OFF_KEY_MAXIMUM: rdata <= kmax_q;
            OFF_STATUS: rdata <= {29'h0, armed_q, state_q};
            default: rdata <= RST_WORD;
         endcase
      end else begin
         rdata <= RST_WORD;
      end
   end

   // active mode decode towards the pixel path
   logic dbl_px, dbl_ln, is_rgb;
   always_comb begin
      is_rgb = a_ctl_q[CTL_FORMAT];
      case (a_ctl_q[CTL_MULT_HI:CTL_MULT_LO])
         MULT_LINE_PIXEL: begin
            dbl_px = 1'b1;
            dbl_ln = 1'b1;
         end
         MULT_PIXEL: begin
            dbl_px = 1'b1;
            dbl_ln = 1'b0;
         end
         default: begin
            // reserved code behaves as no duplication
            dbl_px = 1'b0;
            dbl_ln = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mode <= '0;
      end else begin
         mode.enable <= a_ctl_q[CTL_ENABLE];
         mode.excess512 <= a_ctl_q[CTL_EXCESS512] & a_ctl_q[CTL_CSC_OFF] & ~is_rgb;
         mode.range_expand <= ~a_ctl_q[CTL_RANGE_OFF] & ~is_rgb;
         mode.format_rgb <= is_rgb;
         mode.src_key <= a_ctl_q[CTL_SRC_KEY];
         mode.dst_key <= a_ctl_q[CTL_DST_KEY];
         mode.double_pixels <= dbl_px;
         mode.double_lines <= dbl_ln;
         mode.csc_on <= ~a_ctl_q[CTL_CSC_OFF] & ~is_rgb;
         mode.bt709 <= a_ctl_q[CTL_BT709] & ~is_rgb;
         mode.order <= is_rgb ? ORDER_YUYV
                       : byte_order_t'(a_ctl_q[CTL_ORDER_HI:CTL_ORDER_LO]);
         mode.rotate <= a_ctl_q[CTL_ROTATE];
         mode.tiled <= a_ctl_q[CTL_TILED];
      end
   end

   // fetch setup; x and width are doubled with pixel doubling, y and height only with line doubling
   logic [12:0] px, py, sw, sh;
   always_comb begin
      px = {1'b0, a_pos_q[11:0]};
      py = {1'b0, a_pos_q[27:16]};
      sw = {1'b0, a_size_q[11:0]};
      sh = {1'b0, a_size_q[27:16]};
      if (dbl_px) begin
         px = {a_pos_q[11:0], 1'b0};
         sw = {a_size_q[11:0], 1'b1}; // (w+1)*2-1
      end
      if (dbl_ln) begin
         py = {a_pos_q[27:16], 1'b0};
         sh = {a_size_q[27:16], 1'b1};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         fetch <= '0;
      end else begin
         fetch.fetch_en <= a_ctl_q[CTL_ENABLE];
         // tiled panning comes from a separate offset outside this block
         fetch.start_addr <= a_ctl_q[CTL_TILED] ? a_surf_q : a_surf_q + a_lin_q;
         fetch.stride <= a_stride_q;
         fetch.pos_x <= px;
         fetch.pos_y <= py;
         fetch.width_m1 <= sw;
         fetch.height_m1 <= sh;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         keys <= '0;
      end else begin
         keys.key_min <= a_kval_q[23:0];
         keys.key_max <= a_kmax_q[23:0];
         keys.dst_mask <= a_kmsk_q[23:0];
         keys.range_en <= a_kmsk_q[MSK_V_EN:MSK_U_EN];
      end
   end

   // colour key compare, one pixel per cycle, answer one cycle later.
   // yuv source key uses min/max ranges; rgb source key compares exactly.
   logic [2:0] ch_ok;
   logic dst_match;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_chan
         logic [7:0] s, lo, hi;
         assign s = pix_in.src[8*g +: 8];
         assign lo = a_kval_q[8*g +: 8];
         assign hi = a_kmax_q[8*g +: 8];
         assign ch_ok[g] = !a_kmsk_q[MSK_U_EN + g] ||
                           (is_rgb ? (s == lo) : (s >= lo && s <= hi));
      end
   endgenerate
   assign dst_match = ((pix_in.under ^ a_kval_q[23:0]) & a_kmsk_q[23:0]) == 24'h000000;

   always_ff @(posedge clk) begin
      if (srst) begin
         key_out <= '0;
      end else begin
         key_out.valid <= pix_in.valid;
         key_out.transparent <= pix_in.valid & a_ctl_q[CTL_SRC_KEY] & (&ch_ok);
         // sprite shown while enabled, unless destination key is on and the pixel misses
         key_out.use_sprite <= pix_in.valid & a_ctl_q[CTL_ENABLE] &
                               (~a_ctl_q[CTL_DST_KEY] | dst_match);
      end
   end
endmodule : sprite_plane_control
`default_nettype wire

// ### core/sprite_plane_pkg.sv
/*
 * sprite plane register map, field positions, reset values and carrier types.
 * assumes a 32-bit word-addressed register port carrying byte offsets.
 */
`default_nettype none
package sprite_plane_pkg;
   localparam logic [19:0] OFF_CONTROL = 20'h72180;
   localparam logic [19:0] OFF_LINEAR_OFFSET = 20'h72184;
   localparam logic [19:0] OFF_STRIDE = 20'h72188;
   localparam logic [19:0] OFF_POSITION = 20'h7218C;
   localparam logic [19:0] OFF_SIZE = 20'h72190;
   localparam logic [19:0] OFF_KEY_VALUE = 20'h72194;
   localparam logic [19:0] OFF_KEY_MASK = 20'h72198;
   localparam logic [19:0] OFF_SURFACE_TRIGGER = 20'h7219C;
   localparam logic [19:0] OFF_KEY_MAXIMUM = 20'h721A0;
   localparam logic [19:0] OFF_STATUS = 20'h721B0;

   localparam logic [31:0] RST_WORD = 32'h00000000;
   localparam logic [31:0] CONTROL_WMASK = 32'hDC7F8404;
   localparam logic [31:0] XY_WMASK = 32'h0FFF0FFF;
   localparam logic [31:0] KEY_VALUE_WMASK = 32'h00FFFFFF;
   localparam logic [31:0] KEY_MASK_WMASK = 32'h07FFFFFF;
   localparam logic [31:0] SURF_WMASK = 32'h1FFFF000;

   localparam int CTL_ENABLE = 31;
   localparam int CTL_EXCESS512 = 28;
   localparam int CTL_RANGE_OFF = 27;
   localparam int CTL_FORMAT = 26;
   localparam int CTL_SRC_KEY = 22;
   localparam int CTL_MULT_HI = 21;
   localparam int CTL_MULT_LO = 20;
   localparam int CTL_CSC_OFF = 19;
   localparam int CTL_BT709 = 18;
   localparam int CTL_ORDER_HI = 17;
   localparam int CTL_ORDER_LO = 16;
   localparam int CTL_ROTATE = 15;
   localparam int CTL_TILED = 10;
   localparam int CTL_DST_KEY = 2;
   localparam int MSK_V_EN = 26;
   localparam int MSK_Y_EN = 25;
   localparam int MSK_U_EN = 24;

   localparam logic [1:0] MULT_NONE = 2'h0;
   localparam logic [1:0] MULT_LINE_PIXEL = 2'h1;
   localparam logic [1:0] MULT_PIXEL = 2'h3;

   typedef enum logic [1:0] {
      ORDER_YUYV = 2'h0,
      ORDER_UYVY = 2'h1,
      ORDER_YVYU = 2'h2,
      ORDER_VYUY = 2'h3
   } byte_order_t;

   typedef enum logic [1:0] {
      PLANE_OFF = 2'h0,
      PLANE_ARMED = 2'h1,
      PLANE_ON = 2'h3
   } plane_state_t;

   typedef struct packed {
      logic [19:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic enable;
      logic excess512;
      logic range_expand;
      logic format_rgb;
      logic src_key;
      logic dst_key;
      logic double_pixels;
      logic double_lines;
      logic csc_on;
      logic bt709;
      byte_order_t order;
      logic rotate;
      logic tiled;
   } pixel_mode_t;

   typedef struct packed {
      logic fetch_en;
      logic [31:0] start_addr;
      logic [31:0] stride;
      logic [12:0] pos_x;
      logic [12:0] pos_y;
      logic [12:0] width_m1;
      logic [12:0] height_m1;
   } fetch_cfg_t;

   typedef struct packed {
      logic [23:0] key_min;
      logic [23:0] key_max;
      logic [23:0] dst_mask;
      logic [2:0] range_en;
   } key_cfg_t;

   typedef struct packed {
      logic valid;
      logic [23:0] src;
      logic [23:0] under;
   } pix_in_t;

   typedef struct packed {
      logic valid;
      logic transparent;
      logic use_sprite;
   } key_out_t;
endpackage : sprite_plane_pkg
`default_nettype wire

// ### sim/pipe_model.sv
/*
 * pipe model: holds the vertical blank level high for five cycles per request.
 * assumes go is a one-cycle pulse from the bench in the clk domain.
 */
`default_nettype none
module pipe_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic go,
   output logic vblank
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_q;
   // a level, not a pulse: the plane has to find the rising edge itself
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= 3'h0;
      end else if (go) begin
         cnt_q <= 3'h5;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end
   assign vblank = (cnt_q != 3'h0);
endmodule : pipe_model
`default_nettype wire

// ### sim/sprite_plane_control_checker.sv
/*
 * checker for the sprite plane control block, bound to its ports.
 * assumes srst is synchronous, active high, in the single clk domain.
 */
`default_nettype none
module sprite_plane_control_checker
   import sprite_plane_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire sprite_plane_pkg::reg_req_t req,
   input wire logic [31:0] rdata,
   input wire logic vblank,
   input wire sprite_plane_pkg::pix_in_t pix_in,
   input wire sprite_plane_pkg::pixel_mode_t mode,
   input wire sprite_plane_pkg::fetch_cfg_t fetch,
   input wire sprite_plane_pkg::key_cfg_t keys,
   input wire sprite_plane_pkg::key_out_t key_out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   property p_rd_quiet; !$past(req.rd) |-> rdata == 32'h0; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read");
   property p_key_lat; key_out.valid == $past(pix_in.valid); endproperty
   a_key_lat: assert property (p_key_lat) else $error("key result latency wrong");
   property p_src_off; !mode.src_key |-> !key_out.transparent; endproperty
   a_src_off: assert property (p_src_off) else $error("transparent without key");
   property p_use; mode.enable && !mode.dst_key && $past(pix_in.valid) |-> key_out.use_sprite;
   endproperty
   a_use: assert property (p_use) else $error("sprite pixel not used");
   property p_use_off; !mode.enable |-> !key_out.use_sprite; endproperty
   a_use_off: assert property (p_use_off) else $error("disabled plane shows pixels");
   property p_excess; mode.excess512 |-> !mode.csc_on && !mode.format_rgb; endproperty
   a_excess: assert property (p_excess) else $error("excess-512 outside bypass");
   property p_rgb; mode.format_rgb |-> !mode.bt709 && !mode.range_expand
      && mode.order == ORDER_YUYV; endproperty
   a_rgb: assert property (p_rgb) else $error("yuv setting used for rgb");
   property p_mult; mode.double_lines |-> mode.double_pixels; endproperty
   a_mult: assert property (p_mult) else $error("line doubling alone");
   property p_fetch_en; fetch.fetch_en == mode.enable; endproperty
   a_fetch_en: assert property (p_fetch_en) else $error("fetch enable disagrees");
   // active copies may only move just after a blank edge
   property p_vb_hold; $changed({fetch, keys}) |-> $past(vblank) || $past(vblank, 2)
      || $past(vblank, 3) || $past(vblank, 4); endproperty
   a_vb_hold: assert property (p_vb_hold) else $error("update outside blank");
   c_transparent: cover property (key_out.transparent);
   c_dst_use: cover property (mode.dst_key && key_out.use_sprite);
   c_double: cover property (mode.double_lines);
endmodule : sprite_plane_control_checker
bind sprite_plane_control sprite_plane_control_checker u_checker (.clk(clk), .srst(srst),
   .req(req), .rdata(rdata), .vblank(vblank), .pix_in(pix_in), .mode(mode), .fetch(fetch),
   .keys(keys), .key_out(key_out));
`default_nettype wire

// ### sim/sprite_plane_control_tb_top.sv
/*
 * bench for the sprite plane control block: register port tasks, pipe model
 * for vertical blank, decode, fetch and key checks.
 * assumes the design package and the pipe model are compiled first.
 */
`default_nettype none
module sprite_plane_control_tb_top;
   import sprite_plane_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] WM [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, XY_WMASK, XY_WMASK,
      KEY_VALUE_WMASK, KEY_MASK_WMASK};
   localparam logic [31:0] PXY [4] = '{32'h0000A007, 32'h0001400E, 32'h0000A007, 32'h0000A00E};
   localparam logic [31:0] SXY [4] = '{32'h00012003, 32'h00026007, 32'h00012003, 32'h00012007};
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic go = 1'b0;
   logic vblank;
   reg_req_t req = '0;
   pix_in_t pix_in = '0;
   logic [31:0] rdata;
   pixel_mode_t mode;
   pixel_mode_t exp_mode;
   fetch_cfg_t fetch;
   key_cfg_t keys;
   key_out_t key_out;
   int fails = 0;
   int num_checks = 0;

   initial begin
      forever #12.5 clk = ~clk;
   end

   sprite_plane_control u_dut (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
      .vblank(vblank), .pix_in(pix_in), .mode(mode), .fetch(fetch), .keys(keys),
      .key_out(key_out));
   pipe_model u_pipe (.clk(clk), .srst(srst), .go(go), .vblank(vblank));

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [19:0] a, input logic [31:0] exp);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 check(rdata, exp);
   endtask : rd

   // waits out the blank plus the two-cycle load into the outputs
   task automatic vb();
      int i;
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 8 && vblank !== 1'b1; i++) @(posedge clk);
      if (vblank !== 1'b1) begin
         fails++;
         stop_test();
      end
      repeat (9) @(posedge clk);
      #1;
   endtask : vb

   task automatic arm(input logic [31:0] ctl);
      wr(OFF_CONTROL, ctl);
      wr(OFF_SURFACE_TRIGGER, 32'h00003000);
      vb();
   endtask : arm

   task automatic px(input logic [23:0] s, input logic [23:0] u, input logic [1:0] exp);
      @(posedge clk);
      pix_in <= '{valid: 1'b1, src: s, under: u};
      @(posedge clk);
      pix_in.valid <= 1'b0;
      #1 check(32'({key_out.transparent, key_out.use_sprite}), 32'(exp));
      check(32'(key_out.valid), 32'h1);
   endtask : px

   initial begin
      int i;
      logic [31:0] c;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 6; i++) rd(OFF_LINEAR_OFFSET + 20'(4 * i), RST_WORD);
      rd(OFF_CONTROL, RST_WORD);
      for (i = 0; i < 6; i++) wr(OFF_LINEAR_OFFSET + 20'(4 * i), 32'hFFFFFFFF);
      for (i = 0; i < 6; i++) rd(OFF_LINEAR_OFFSET + 20'(4 * i), WM[i]);
      wr(OFF_CONTROL, 32'hFFFFFFFF);
      rd(OFF_CONTROL, CONTROL_WMASK);
      wr(20'h721A8, 32'hFFFFFFFF);
      rd(20'h721A8, 32'h0);
      // linear panning, stride and the trigger; offsets pixel aligned, strides 512 aligned
      wr(OFF_LINEAR_OFFSET, 32'h40);
      wr(OFF_STRIDE, 32'h200);
      arm(32'h80000000);
      check(fetch.start_addr, 32'h3040);
      check(fetch.stride, 32'h200);
      check(32'(fetch.fetch_en), 32'h1);
      rd(OFF_STATUS, 32'h3);
      wr(OFF_LINEAR_OFFSET, 32'h80);
      wr(OFF_STRIDE, 32'h400);
      check(fetch.start_addr, 32'h3040);
      vb();
      check(fetch.start_addr, 32'h3080);
      check(fetch.stride, 32'h200);
      arm(32'h80000400);
      check(fetch.start_addr, 32'h3000);
      check(32'(mode.tiled), 32'h1);
      check(fetch.stride, 32'h400);
      // every multiply code, reserved one behaves as none; width stays even
      wr(OFF_POSITION, 32'h00050007);
      wr(OFF_SIZE, 32'h00090003);
      for (i = 0; i < 4; i++) begin
         arm(32'h80000000 | (32'(i) << 20));
         check(32'({mode.double_pixels, mode.double_lines}), 32'({i[0], i == 1}));
         check(32'({fetch.pos_y, fetch.pos_x}), PXY[i]);
         check(32'({fetch.height_m1, fetch.width_m1}), SXY[i]);
      end
      // format, bypass, standard, byte order and rotation
      for (i = 0; i < 8; i++) begin
         c = 32'h90040000 | (32'(i[2]) << 26) | (32'(i[1:0]) << 16) | (32'(i[0]) << 19);
         arm(c | (32'(i[1]) << 15));
         exp_mode = '0;
         exp_mode.enable = 1'b1;
         exp_mode.format_rgb = i[2];
         exp_mode.excess512 = i[0] & !i[2];
         exp_mode.range_expand = !i[2];
         exp_mode.csc_on = !i[0] & !i[2];
         exp_mode.bt709 = !i[2];
         exp_mode.order = i[2] ? ORDER_YUYV : byte_order_t'(i[1:0]);
         exp_mode.rotate = i[1];
         check(32'(mode), 32'(exp_mode));
      end
      // source key ranges, edges inclusive
      wr(OFF_KEY_VALUE, 32'h00102030);
      wr(OFF_KEY_MAXIMUM, 32'h00405060);
      wr(OFF_KEY_MASK, 32'h07000000);
      arm(32'h80400000);
      check(32'(keys.range_en), 32'h7);
      check(32'(keys.key_min), 32'h00102030);
      check(32'(keys.key_max), 32'h00405060);
      check(32'(mode.src_key), 32'h1);
      px(24'h304050, 24'h0, 2'b11);
      px(24'h102060, 24'h0, 2'b11);
      px(24'h304061, 24'h0, 2'b01);
      wr(OFF_KEY_MASK, 32'h06000000);
      arm(32'h80400000);
      px(24'h304061, 24'h0, 2'b11);
      px(24'h0F4050, 24'h0, 2'b01);
      arm(32'h84400000);
      px(24'h1020FF, 24'h0, 2'b11);
      px(24'h1021FF, 24'h0, 2'b01);
      // destination key with masked bits
      wr(OFF_KEY_VALUE, 32'h00112233);
      wr(OFF_KEY_MASK, 32'h00FF00FF);
      arm(32'h80000004);
      check(32'(keys.dst_mask), 32'h00FF00FF);
      check(32'(mode.dst_key), 32'h1);
      px(24'h0, 24'h11AA33, 2'b01);
      px(24'h0, 24'h12AA33, 2'b00);
      // disable needs no trigger
      wr(OFF_CONTROL, 32'h0);
      vb();
      check(32'(fetch.fetch_en), 32'h0);
      rd(OFF_STATUS, 32'h0);
      px(24'h0, 24'h112233, 2'b00);
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule : sprite_plane_control_tb_top
`default_nettype wire
